/* pts_timer.sv */
// Summary of operation
// - instruction clock prescaled 1, 4 or 16
// - count up, wrap to zero after period
// - period register 8-bit, resets to FFh
// - count register read/write, reset to zero
// - postscaler 1..16 sets sticky match flag
// - clearing run bit stops counting
// - count write clears both scalers
// - control write clears both scalers
// - control write leaves count unchanged
// - any device reset clears both scalers
// - unscaled match goes to serial port
// - count and match serve PWM timebase
`default_nettype none

module pts_timer (
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         nrst,
    // avalon-mm slave
    input  wire logic [pts_pkg::PTS_ADDR_W-1:0] address,
    input  wire logic                         read,
    input  wire logic                         write,
    input  wire logic [pts_pkg::PTS_DATA_W-1:0] writedata,
    output logic      [pts_pkg::PTS_DATA_W-1:0] readdata,
    output logic                              waitrequest,
    // interrupt
    output logic                              irq,
    // time base for serial port and pwm unit
    output logic                              period_match_out,
    output logic      [pts_pkg::PTS_REG_W-1:0]  timer_count_out
);
    import pts_pkg::*;

    // registers
    logic [PTS_REG_W-1:0] timer_count;        // running count
    logic [PTS_REG_W-1:0] period_register;    // match value
    logic [PTS_REG_W-1:0] timer_control;      // divider select, run, postscale
    logic [PTS_REG_W-1:0] peripheral_flag_reg;   // sticky flags
    logic [PTS_REG_W-1:0] peripheral_enable_reg; // interrupt mask

    // bus decode
    logic                 acc_ok;             // access completes this cycle
    logic                 wr_now;             // write takes effect this edge
    logic                 wr_count;
    logic                 wr_period;
    logic                 wr_ctrl;
    logic                 wr_flags;
    logic                 wr_enables;
    logic [PTS_REG_W-1:0] wdat;               // low byte of write data
    logic [PTS_DATA_W-1:0] next_readdata;

    // scaler plumbing
    logic                 timer_run;
    logic [1:0]           input_divider_select;
    logic [3:0]           post_limit;
    logic [3:0]           pre_limit;
    logic                 scaler_clear;
    logic                 instr_tick;         // instruction clock enable
    logic [3:0]           pre_cnt;
    logic                 count_tick;         // prescaled increment
    logic [3:0]           post_cnt;
    logic                 post_expire;
    logic                 match_now;          // count equals period on a tick

    assign acc_ok     = (read || write) && !waitrequest;
    assign wr_now     = write && !waitrequest;
    assign wdat       = writedata[PTS_REG_W-1:0];
    assign wr_count   = wr_now && (address == PTS_OFS_COUNT);
    assign wr_period  = wr_now && (address == PTS_OFS_PERIOD);
    assign wr_ctrl    = wr_now && (address == PTS_OFS_CONTROL);
    assign wr_flags   = wr_now && (address == PTS_OFS_FLAGS);
    assign wr_enables = wr_now && (address == PTS_OFS_ENABLES);

    assign timer_run            = timer_control[PTS_CTL_RUN_BIT];
    assign input_divider_select = timer_control[PTS_CTL_PRE_LSB +: 2];
    assign post_limit           = timer_control[PTS_CTL_POST_LSB +: 4];

    // both scalers restart on either write; async reset clears them too
    assign scaler_clear = wr_count || wr_ctrl;

    // divider select to terminal count
    always_comb begin
        case (input_divider_select)
            PTS_PRE_DIV1: pre_limit = PTS_PRE_LIM1;
            PTS_PRE_DIV4: pre_limit = PTS_PRE_LIM4;
            default:      pre_limit = PTS_PRE_LIM16;
        endcase
    end

    // instruction clock: system clock divided by four, free running
    pts_scaler #(.W(2)) u_instr (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .clear   (1'b0),
        .step    (1'b1),
        .limit   (PTS_INSTR_LIMIT),
        .cnt     (),
        .expire  (instr_tick)
    );

    // prescaler, gated by the run bit so a stopped timer holds still
    pts_scaler #(.W(4)) u_pre (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .clear   (scaler_clear),
        .step    (instr_tick && timer_run),
        .limit   (pre_limit),
        .cnt     (pre_cnt),
        .expire  (count_tick)
    );

    assign match_now = count_tick && (timer_count == period_register);

    // postscaler counts period matches
    pts_scaler #(.W(4)) u_post (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .clear   (scaler_clear),
        .step    (match_now),
        .limit   (post_limit),
        .cnt     (post_cnt),
        .expire  (post_expire)
    );

    // the count: software write wins over a tick in the same cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer_count <= PTS_RST_COUNT;
        end else if (wr_count) begin
            timer_count <= wdat;
        end else if (match_now) begin
            timer_count <= PTS_RST_COUNT;
        end else if (count_tick) begin
            timer_count <= timer_count + 8'h01;
        end
    end

    // period register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            period_register <= PTS_RST_PERIOD;
        end else if (wr_period) begin
            period_register <= wdat;
        end
    end

    // control register; the count itself is not touched here
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer_control <= PTS_RST_CONTROL;
        end else if (wr_ctrl) begin
            timer_control <= wdat & PTS_REG_W'((1 << PTS_CTL_USED_W) - 1);
        end
    end

    // sticky flags: write one to clear, a same-cycle postscaler expiry still sets
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            peripheral_flag_reg <= PTS_RST_FLAGS;
        end else begin
            if (wr_flags) begin
                peripheral_flag_reg[PTS_FLG_MATCH_BIT] <= peripheral_flag_reg[PTS_FLG_MATCH_BIT]
                                                         & ~wdat[PTS_FLG_MATCH_BIT];
            end
            if (post_expire) begin
                peripheral_flag_reg[PTS_FLG_MATCH_BIT] <= 1'b1;
            end
        end
    end

    // interrupt mask, all bits stored
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            peripheral_enable_reg <= PTS_RST_ENABLES;
        end else if (wr_enables) begin
            peripheral_enable_reg <= wdat;
        end
    end

    // level interrupt, one cycle behind the flag
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(peripheral_flag_reg & peripheral_enable_reg);
        end
    end

    // time base outputs; match is a pulse before the postscaler
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            period_match_out <= 1'b0;
            timer_count_out  <= PTS_RST_COUNT;
        end else begin
            period_match_out <= match_now;
            timer_count_out  <= next_count_view(timer_count, wr_count, wdat, match_now, count_tick);
        end
    end

    // mirror of the count as it will stand after this edge
    function automatic logic [7:0] next_count_view(input logic [7:0] cur, input logic wr,
                                                   input logic [7:0] d, input logic m, input logic t);
        logic [7:0] v;
        v = cur;
        if (wr) begin
            v = d;
        end else if (m) begin
            v = PTS_RST_COUNT;
        end else if (t) begin
            v = cur + 8'h01;
        end
        return v;
    endfunction : next_count_view

    // read mux; unmapped addresses read zero
    always_comb begin
        next_readdata = '0;
        case (address)
            PTS_OFS_COUNT:   next_readdata[PTS_REG_W-1:0] = timer_count;
            PTS_OFS_PERIOD:  next_readdata[PTS_REG_W-1:0] = period_register;
            PTS_OFS_CONTROL: next_readdata[PTS_REG_W-1:0] = timer_control;
            PTS_OFS_FLAGS:   next_readdata[PTS_REG_W-1:0] = peripheral_flag_reg;
            PTS_OFS_ENABLES: next_readdata[PTS_REG_W-1:0] = peripheral_enable_reg;
            default:         next_readdata = '0;
        endcase
    end

    // fixed one wait state: waitrequest drops for a single cycle per access
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
            readdata    <= '0;
        end else if (acc_ok) begin
            waitrequest <= 1'b1;
        end else if (read || write) begin
            waitrequest <= 1'b0;
            readdata    <= read ? next_readdata : '0;
        end
    end

    // ---- checks ----
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_wrap;
        count_tick && (timer_count == period_register) && !wr_count;
    endsequence

    sequence s_step;
        count_tick && (timer_count != period_register) && !wr_count;
    endsequence

    sequence s_bus_req;
        (read || write) && waitrequest;
    endsequence

    chk_count_wrap: assert property (s_wrap |=> timer_count == PTS_RST_COUNT ##0 period_match_out)
        else $error("count did not wrap to zero with match pulse");
    chk_count_step: assert property (s_step |=> timer_count == $past(timer_count) + 8'h01)
        else $error("count did not step by one");
    chk_period_write: assert property (wr_period |=> period_register == $past(wdat))
        else $error("period write lost");
    chk_count_write: assert property (wr_count |=> timer_count == $past(wdat))
        else $error("count write lost");
    chk_run_stop: assert property (!timer_run && !wr_count && !wr_ctrl |=> $stable(timer_count))
        else $error("count moved while stopped");
    chk_count_clear: assert property (wr_count |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
        else $error("scalers not cleared by count write");
    chk_ctrl_clear: assert property (wr_ctrl |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
        else $error("scalers not cleared by control write");
    chk_ctrl_keep: assert property (wr_ctrl && !wr_count |=> $stable(timer_count))
        else $error("control write changed count");
    // irq lags the flag by one edge, so the mask that matters is the one seen with the flag
    chk_flag_set: assert property (post_expire |=> peripheral_flag_reg[PTS_FLG_MATCH_BIT]
                                   ##1 (irq || !$past(peripheral_enable_reg[PTS_FLG_MATCH_BIT])))
        else $error("postscaler expiry did not raise flag");
    chk_flag_sticky: assert property (peripheral_flag_reg[PTS_FLG_MATCH_BIT] && !wr_flags
                                      |=> peripheral_flag_reg[PTS_FLG_MATCH_BIT])
        else $error("match flag cleared without software");
    // every bus path to run clears the scalers itself, so reset clearing is only visible here
    chk_rst_scalers: assert property (@(posedge clk_sys) disable iff (1'b0)
                                      $rose(nrst) |-> pre_cnt == 4'h0 && post_cnt == 4'h0)
        else $error("scalers not cleared by reset");
    chk_bus_answer: assert property (s_bus_req |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one wait state");

endmodule : pts_timer

`default_nettype wire

/* pts_pkg.sv */
`default_nettype none

package pts_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] PTS_OFS_COUNT   = 8'h10;  // timer_count_value
    localparam logic [7:0] PTS_OFS_PERIOD  = 8'h14;  // timer_period
    localparam logic [7:0] PTS_OFS_CONTROL = 8'h18;  // timer_control
    localparam logic [7:0] PTS_OFS_FLAGS   = 8'h0C;  // peripheral_irq_flags
    localparam logic [7:0] PTS_OFS_ENABLES = 8'h8C;  // peripheral_irq_enables

    // bus and data widths
    localparam int PTS_ADDR_W = 8;
    localparam int PTS_DATA_W = 32;
    localparam int PTS_REG_W  = 8;

    // control field layout
    localparam int PTS_CTL_PRE_LSB  = 0;  // input_divider_select, 2 bits
    localparam int PTS_CTL_RUN_BIT  = 2;  // timer_run
    localparam int PTS_CTL_POST_LSB = 3;  // postscaler ratio minus one, 4 bits
    localparam int PTS_CTL_USED_W   = 7;  // bits above read as zero

    // flag / enable layout
    localparam int PTS_FLG_MATCH_BIT = 1;  // period_match_flag / period_match_irq_enable

    // reset values
    localparam logic [7:0] PTS_RST_COUNT   = 8'h00;
    localparam logic [7:0] PTS_RST_PERIOD  = 8'hFF;
    localparam logic [7:0] PTS_RST_CONTROL = 8'h00;
    localparam logic [7:0] PTS_RST_FLAGS   = 8'h00;
    localparam logic [7:0] PTS_RST_ENABLES = 8'h00;

    // instruction clock is the system clock divided by four
    localparam logic [1:0] PTS_INSTR_LIMIT = 2'h3;

    // prescaler select codes and their terminal counts
    localparam logic [1:0] PTS_PRE_DIV1  = 2'h0;
    localparam logic [1:0] PTS_PRE_DIV4  = 2'h1;
    localparam logic [3:0] PTS_PRE_LIM1  = 4'h0;
    localparam logic [3:0] PTS_PRE_LIM4  = 4'h3;
    localparam logic [3:0] PTS_PRE_LIM16 = 4'hF;

endpackage : pts_pkg

`default_nettype wire

/* pts_scaler.sv */
`default_nettype none

// free divide counter: pulses expire on the step taken while the count is at or above limit
module pts_scaler #(
    parameter int W = 4                  // counter width
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // control
    input  wire logic         clear,     // synchronous clear, wins over step
    input  wire logic         step,      // one-cycle count enable
    input  wire logic [W-1:0] limit,     // terminal count
    // results
    output logic      [W-1:0] cnt,       // present count
    output logic              expire     // one-cycle pulse
);

    // expire is suppressed on a clear so a cleared scaler never leaks a tick
    assign expire = step && !clear && (cnt >= limit);

    // count, wrap at limit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
        end else if (clear) begin
            cnt <= '0;
        end else if (expire) begin
            cnt <= '0;
        end else if (step) begin
            cnt <= cnt + W'(1);
        end
    end

endmodule : pts_scaler

`default_nettype wire

/* tb_top.sv */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pts_pkg::*;

    // clock, reset and bus drive
    logic                  clk_sys;
    logic                  nrst;
    logic [PTS_ADDR_W-1:0] address;
    logic                  read;
    logic                  write;
    logic [PTS_DATA_W-1:0] writedata;
    // design outputs
    logic [PTS_DATA_W-1:0] readdata;
    logic                  waitrequest;
    logic                  irq;
    logic                  period_match_out;
    logic [PTS_REG_W-1:0]  timer_count_out;
    // bookkeeping
    int                    n_fail;
    int                    checked;
    int                    cyc = 0;
    int                    n;
    int                    m;
    logic [3:0]            posts [3] = '{4'h0, 4'h3, 4'hF};
    int                    steps [4] = '{4, 16, 64, 64};

    pts_timer pts_timer_i (
        .clk_sys          (clk_sys),
        .nrst             (nrst),
        .address          (address),
        .read             (read),
        .write            (write),
        .writedata        (writedata),
        .readdata         (readdata),
        .waitrequest      (waitrequest),
        .irq              (irq),
        .period_match_out (period_match_out),
        .timer_count_out  (timer_count_out)
    );

    // 100 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // value compare, four-state exact
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_val

    // measured cycle count against a window
    task automatic cmp_rng(input int got, input int lo, input int hi, input string what);
        checked++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("BAD %0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : cmp_rng

    // one avalon access; an idle edge after release keeps drivers from double assignment
    task automatic bus_acc(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        k = 0;
        address <= a;
        writedata <= wd;
        read <= ~wr;
        write <= wr;
        // no local limit: only the hang guard ends a wait for the answer
        do begin
            @(posedge clk_sys);
            k++;
        end while (waitrequest !== 1'b0);
        cmp_rng(k, 2, 2, "bus answer");
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus_acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus_acc(1'b1, a, {24'h0, d}, x);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
        logic [31:0] x;
        bus_acc(1'b0, a, 32'h0, x);
        cmp_val(x, {24'h0, e}, what);
    endtask : rd_chk

    // control byte from its fields
    function automatic logic [7:0] ctl(input logic run, input logic [1:0] sel, input logic [3:0] post);
        ctl = 8'h00;
        ctl[PTS_CTL_PRE_LSB +: 2] = sel;
        ctl[PTS_CTL_RUN_BIT] = run;
        ctl[PTS_CTL_POST_LSB +: 4] = post;
    endfunction : ctl

    // cycles until the visible count moves
    task automatic wait_chg(output int k);
        logic [7:0] v;
        k = 0;
        v = timer_count_out;
        while (timer_count_out === v && k < 300) begin
            @(posedge clk_sys);
            k++;
        end
    endtask : wait_chg

    // cycles until the next unscaled match pulse
    task automatic wait_pulse(output int k);
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (period_match_out !== 1'b1 && k < 300);
    endtask : wait_pulse

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        {nrst, read, write, address, writedata, n_fail, checked} = '0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        // reset values and an unmapped hole
        rd_chk(PTS_OFS_PERIOD, 8'hFF, "period rst");
        rd_chk(PTS_OFS_COUNT, 8'h00, "count rst");
        rd_chk(PTS_OFS_CONTROL, 8'h00, "ctl rst");
        rd_chk(PTS_OFS_FLAGS, 8'h00, "flags rst");
        rd_chk(PTS_OFS_ENABLES, 8'h00, "en rst");
        rd_chk(8'h40, 8'h00, "unmapped");
        // stopped timer holds; count read/write and pwm copy
        repeat (40) @(posedge clk_sys);
        cmp_val(timer_count_out, 8'h00, "stopped");
        wr(PTS_OFS_COUNT, 8'h5A);
        rd_chk(PTS_OFS_COUNT, 8'h5A, "count rw");
        cmp_val(timer_count_out, 8'h5A, "pwm base");
        wr(PTS_OFS_CONTROL, ctl(1'b0, PTS_PRE_DIV4, 4'h5));
        rd_chk(PTS_OFS_COUNT, 8'h5A, "ctl keeps");
        // every divider code: interval between increments
        for (int s = 0; s < 4; s++) begin
            wr(PTS_OFS_CONTROL, ctl(1'b1, s[1:0], 4'h0));
            wait_chg(n);
            wait_chg(n);
            cmp_rng(n, steps[s], steps[s], "divider");
        end
        // scalers cleared by count write, then by control write (1:16 running)
        wait_chg(n);
        repeat (32) @(posedge clk_sys);
        wr(PTS_OFS_COUNT, 8'h10);
        wait_chg(n);
        cmp_rng(n, 56, 66, "count wr clr");
        repeat (32) @(posedge clk_sys);
        wr(PTS_OFS_CONTROL, ctl(1'b1, 2'h3, 4'h0));
        wait_chg(n);
        cmp_rng(n, 56, 66, "ctl wr clr");
        // wrap at period and unscaled match spacing
        wr(PTS_OFS_CONTROL, 8'h00);
        wr(PTS_OFS_COUNT, 8'h00);
        wr(PTS_OFS_PERIOD, 8'h03);
        rd_chk(PTS_OFS_PERIOD, 8'h03, "period rw");
        wr(PTS_OFS_CONTROL, ctl(1'b1, PTS_PRE_DIV1, 4'h0));
        wait_pulse(n);
        wait_pulse(n);
        cmp_rng(n, 16, 16, "match spacing");
        cmp_val(timer_count_out, 8'h00, "wrap zero");
        // postscaler ratios at the bounds and one between (1:1, 1:4, 1:16)
        wr(PTS_OFS_PERIOD, 8'h07);
        wr(PTS_OFS_ENABLES, 8'h02);
        foreach (posts[i]) begin
            wr(PTS_OFS_CONTROL, 8'h00);
            wr(PTS_OFS_COUNT, 8'h00);
            wr(PTS_OFS_FLAGS, 8'h02);
            wr(PTS_OFS_CONTROL, ctl(1'b1, PTS_PRE_DIV1, posts[i]));
            n = 0;
            m = 0;
            while (irq !== 1'b1 && m < 1000) begin
                @(posedge clk_sys);
                m++;
                if (period_match_out === 1'b1) begin
                    n++;
                end
            end
            cmp_rng(n, posts[i] + 1, posts[i] + 1, "postscale");
        end
        // sticky flag, masking and write-one clear
        wr(PTS_OFS_CONTROL, 8'h00);
        wr(PTS_OFS_ENABLES, 8'h00);
        repeat (2) @(posedge clk_sys);
        cmp_val({31'h0, irq}, 32'h0, "irq masked");
        wr(PTS_OFS_FLAGS, 8'h00);
        rd_chk(PTS_OFS_FLAGS, 8'h02, "flag sticky");
        wr(PTS_OFS_ENABLES, 8'h02);
        repeat (2) @(posedge clk_sys);
        cmp_val({31'h0, irq}, 32'h1, "irq on");
        wr(PTS_OFS_FLAGS, 8'h02);
        rd_chk(PTS_OFS_FLAGS, 8'h00, "flag clr");
        repeat (2) @(posedge clk_sys);
        cmp_val({31'h0, irq}, 32'h0, "irq off");
        // second reset in mid-run; 1:16 so the prescaler holds a nonzero count when reset hits
        wr(PTS_OFS_CONTROL, ctl(1'b1, 2'h3, 4'hF));
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd_chk(PTS_OFS_PERIOD, 8'hFF, "period rst2");
        rd_chk(PTS_OFS_COUNT, 8'h00, "count rst2");
        rd_chk(PTS_OFS_CONTROL, 8'h00, "ctl rst2");
        final_report();
    end

endmodule : tb_top

`default_nettype wire
